// *** rtl/pwr_stream_pkg.sv ***
package pwr_stream_pkg;
  // command codes
  localparam logic [7:0] cmd_power_query     = 8'he5;
  localparam logic [7:0] cmd_power_query_alt = 8'h98;
  localparam logic [7:0] cmd_stream_config   = 8'h51;
  // power mode answers
  localparam logic [7:0] power_code_standby  = 8'h00;
  localparam logic [7:0] power_code_active   = 8'hff;
  // feature byte fields
  localparam int feat_add_bit    = 7;
  localparam int feat_dir_bit    = 6;
  localparam int feat_id_lsb     = 0;
  localparam int stream_id_width = 3;
  localparam int stream_count    = 8;
  // error and status bit positions
  localparam int err_abort_bit   = 2;
  localparam int stat_busy_bit   = 7;
  localparam int stat_ready_bit  = 6;
  localparam int stat_seek_bit   = 4;
  localparam int stat_err_bit    = 0;
  // reset values
  localparam logic [7:0] status_reset = 8'h50;
  localparam logic [7:0] error_reset  = 8'h00;
  localparam logic [7:0] count_reset  = 8'h00;
  // device power states
  typedef enum logic [1:0] {pwr_active, pwr_idle, pwr_standby, pwr_sleep} power_state_t;
endpackage

// *** rtl/stream_slot_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// carries one stream slot's update request and its stored contents
interface stream_slot_if;
  logic       write_en;
  logic       clear_en;
  logic       new_dir;
  logic [7:0] new_param;
  logic       valid;
  logic       dir;
  logic [7:0] param;
  modport owner (input write_en, input clear_en, input new_dir, input new_param,
                 output valid, output dir, output param);
  modport user  (output write_en, output clear_en, output new_dir, output new_param,
                 input valid, input dir, input param);
endinterface
`default_nettype wire

// *** rtl/stream_slot.sv ***
`timescale 1ns/100ps
`default_nettype none
// one stored stream configuration
module stream_slot (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // slot access
  stream_slot_if.owner slot
);
  typedef struct packed {
    logic       valid;
    logic       dir;
    logic [7:0] param;
  } slot_state_t;

  slot_state_t st;
  slot_state_t next_st;

  // write replaces, clear invalidates; otherwise hold
  always_comb begin
    next_st = st;
    if (slot.write_en) begin
      next_st.valid = 1'b1;
      next_st.dir   = slot.new_dir;
      next_st.param = slot.new_param;
    end else if (slot.clear_en) begin
      next_st.valid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign slot.valid = st.valid;
  assign slot.dir   = st.dir;
  assign slot.param = st.param;
endmodule
`default_nettype wire

// *** rtl/pwr_stream_cmd.sv ***
// Functional notes
// (RL1) E5h and 98h both mean power query
// (RL2) power query reports spindle ready state
// (RL3) standby or sleep returns zero count
// (RL4) other states return all-ones count
// (RL5) 51h decodes as stream configuration
// (RL6) host configures one stream per command
// (RL7) add on valid id overwrites parameters
// (RL8) aborted command leaves stored stream untouched
// (RL9) abort when streaming not supported
// (RL10) abort removing never-configured stream id
// (RL11) feature bit 7 selects add or remove
// (RL12) feature bit 6 selects read or write
// (RL13) feature low three bits hold id
// (RL14) abort sets abort and error, clears busy
`timescale 1ns/100ps
`default_nettype none
module pwr_stream_cmd #(
  // number of stream slots; the three-bit id field reaches eight
  parameter int n_streams = pwr_stream_pkg::stream_count
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // command block writes from the host side
  input  wire logic                         cmd_write,
  input  wire logic [7:0]                   cmd_code,
  input  wire logic [7:0]                   feature_cur,
  input  wire logic [7:0]                   feature_prev,
  // device context
  input  wire pwr_stream_pkg::power_state_t power_state,
  input  wire logic                         streaming_supported,
  // command block results
  output logic [7:0]                        sector_count,
  output logic [7:0]                        error_reg,
  output logic [7:0]                        status_reg,
  output logic                              cmd_done,
  output logic                              cmd_unhandled,
  // stored stream view
  output logic [n_streams-1:0]              stream_valid,
  output logic [n_streams-1:0]              stream_write_dir
);
  // command phases: latch, execute, report
  typedef enum logic [1:0] {st_idle, st_exec, st_finish} phase_t;

  // everything the sequencer remembers, registered as one word
  typedef struct packed {
    phase_t     phase;
    logic [7:0] code;
    logic [7:0] feat;
    logic [7:0] feat_prev;
    logic [7:0] count;
    logic [7:0] error;
    logic [7:0] status;
    logic       done;
    logic       unhandled;
  } cmd_state_t;

  cmd_state_t st;
  cmd_state_t next_st;

  // width of the stream id field, used to size slot index compares
  localparam int id_w = pwr_stream_pkg::stream_id_width;

  // feature byte decode and slot selection
  logic [id_w-1:0]      sel_id;
  logic [n_streams-1:0] sel_hit;
  logic                 want_add;
  logic                 sel_valid;

  // command decode of the latched code and of the live power state
  logic                 is_power_query;
  logic                 is_stream_code;
  logic                 spun_down;

  // accept and per-command actions
  logic                 accept;
  logic                 do_abort;
  logic                 do_write;
  logic                 do_clear;
  logic                 is_stream;

  // one interface per slot carries its strobes and stored contents
  stream_slot_if slots [n_streams] ();

  // one storage slot per stream id
  for (genvar i = 0; i < n_streams; i++) begin : g_slot
    stream_slot u_slot (
      .clk  (clk),
      .rst_n(rst_n),
      .slot (slots[i].owner)
    );
    // id compare cut to the field width on purpose
    assign sel_hit[i]          = (sel_id == id_w'(i));
    // only the addressed slot sees the strobe; the others hold
    assign slots[i].write_en   = do_write && sel_hit[i];
    assign slots[i].clear_en   = do_clear && sel_hit[i];
    // new contents come straight from the latched feature bytes
    assign slots[i].new_dir   = st.feat[pwr_stream_pkg::feat_dir_bit]; // RL12
    assign slots[i].new_param = st.feat_prev;
    assign stream_valid[i]     = slots[i].valid;
    assign stream_write_dir[i] = slots[i].dir;
  end

  // feature byte decode of the latched command
  assign sel_id   = st.feat[pwr_stream_pkg::feat_id_lsb +: id_w]; // RL13
  assign want_add = st.feat[pwr_stream_pkg::feat_add_bit]; // RL11

  // command decode; both query codes share one path
  assign is_power_query = (st.code == pwr_stream_pkg::cmd_power_query) ||
                          (st.code == pwr_stream_pkg::cmd_power_query_alt); // RL1
  assign is_stream_code = (st.code == pwr_stream_pkg::cmd_stream_config); // RL5

  // spindle stopped in standby and sleep; every other state counts as spun up
  assign spun_down      = (power_state == pwr_stream_pkg::pwr_standby) ||
                          (power_state == pwr_stream_pkg::pwr_sleep); // RL2

  // the host may only start a command while no other one is in flight
  assign accept = (st.phase == st_idle) && cmd_write;

  // valid flag of the selected slot, looked up by index in the valid vector;
  // the interface array itself cannot be indexed by a loop variable
  always_comb begin
    sel_valid = 1'b0;
    for (int i = 0; i < n_streams; i++) begin
      if (sel_hit[i]) begin
        sel_valid = stream_valid[i];
      end
    end
  end

  // abort decision gates any slot update, so old parameters survive;
  // a remove of an id never configured, or any stream command without
  // the feature set, aborts, while an add on a valid id simply overwrites
  assign is_stream = (st.phase == st_exec) && is_stream_code; // RL5
  assign do_abort  = !streaming_supported || (!want_add && !sel_valid); // RL9 RL10
  assign do_write  = is_stream && !do_abort && want_add; // RL7 RL8
  assign do_clear  = is_stream && !do_abort && !want_add; // RL8

  // command sequencer: latch, execute, report
  //   accept edge : command block latched, busy set, error cleared
  //   exec edge   : count or abort flags written, slot strobed
  //   finish edge : busy cleared, done pulsed for one cycle
  // a write while busy is ignored; the host must wait for done
  always_comb begin
    next_st           = st;
    // pulses default low so they stand for one cycle only
    next_st.done      = 1'b0;
    next_st.unhandled = 1'b0;
    case (st.phase)
      st_idle: begin
        // latch the command block so later host writes cannot disturb it
        if (accept) begin
          next_st.phase     = st_exec;
          next_st.code      = cmd_code;
          next_st.feat      = feature_cur;
          next_st.feat_prev = feature_prev;
          // busy rises at once; the last command's error report is wiped
          next_st.status[pwr_stream_pkg::stat_busy_bit] = 1'b1;
          next_st.status[pwr_stream_pkg::stat_err_bit]  = 1'b0;
          next_st.error = pwr_stream_pkg::error_reset;
        end
      end
      st_exec: begin
        // results settle here, one cycle before busy falls
        next_st.phase = st_finish;
        if (is_power_query) begin // RL1
          // spun-down states report zero, anything spinning reports all ones
          if (spun_down) begin // RL2
            next_st.count = pwr_stream_pkg::power_code_standby; // RL3
          end else begin
            next_st.count = pwr_stream_pkg::power_code_active; // RL4
          end
        end else if (is_stream_code) begin // RL5 RL6
          // the slot strobes are gated by do_abort outside this process
          if (do_abort) begin
            next_st.error[pwr_stream_pkg::err_abort_bit] = 1'b1; // RL14
            next_st.status[pwr_stream_pkg::stat_err_bit] = 1'b1; // RL14
          end
        end else begin
          // other codes belong to other handlers; report and stay quiet
          next_st.unhandled = 1'b1;
        end
      end
      st_finish: begin
        // busy falls with the done pulse, so the host sees both together
        next_st.phase = st_idle;
        next_st.done  = 1'b1;
        next_st.status[pwr_stream_pkg::stat_busy_bit] = 1'b0; // RL14
      end
      default: begin
        // unused phase encoding falls back to idle
        next_st.phase = st_idle;
      end
    endcase
  end

  // state register; synchronous reset to the idle view
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // every field gets its reset value once
      st.phase     <= st_idle;
      st.code      <= 8'h00;
      st.feat      <= 8'h00;
      st.feat_prev <= 8'h00;
      st.count     <= pwr_stream_pkg::count_reset;
      st.error     <= pwr_stream_pkg::error_reset;
      st.status    <= pwr_stream_pkg::status_reset;
      st.done      <= 1'b0;
      st.unhandled <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // register views straight from the state; no logic after the flops
  assign sector_count  = st.count;
  assign error_reg     = st.error;
  assign status_reg    = st.status;
  assign cmd_done      = st.done;
  assign cmd_unhandled = st.unhandled;
endmodule
`default_nettype wire

// *** sim/pwr_stream_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module pwr_stream_monitor #(parameter int n_streams = 8) (
  // watched ports
  input wire logic                         clk,
  input wire logic                         rst_n,
  input wire logic                         cmd_write,
  input wire logic [7:0]                   cmd_code,
  input wire logic [7:0]                   feature_cur,
  input wire pwr_stream_pkg::power_state_t power_state,
  input wire logic                         streaming_supported,
  input wire logic [7:0]                   sector_count,
  input wire logic [7:0]                   error_reg,
  input wire logic [7:0]                   status_reg,
  input wire logic                         cmd_done,
  input wire logic                         cmd_unhandled,
  input wire logic [n_streams-1:0]         stream_valid,
  input wire logic [n_streams-1:0]         stream_write_dir
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // accepted commands and the abort condition seen at accept time
  wire acc = cmd_write && !status_reg[7];
  wire acc51 = acc && cmd_code == pwr_stream_pkg::cmd_stream_config;
  wire accpq = acc && (cmd_code == 8'he5 || cmd_code == 8'h98);
  wire bad = !streaming_supported || (!feature_cur[7] && !stream_valid[feature_cur[2:0]]);
  wire acc_other = acc && !accpq && cmd_code != pwr_stream_pkg::cmd_stream_config;
  // slot index captured at accept, since the host drops the feature byte afterwards
  property add_p;
    logic [2:0] id;
    logic d;
    (acc51 && !bad && feature_cur[7], id = feature_cur[2:0], d = feature_cur[6])
      |-> ##3 stream_valid[id] && stream_write_dir[id] == d;
  endproperty
  property rem_p;
    logic [2:0] id;
    (acc51 && !bad && !feature_cur[7], id = feature_cur[2:0])
      |-> ##2 !error_reg[2] ##1 !stream_valid[id];
  endproperty
  busy_window_a: assert property (acc |=> status_reg[7] && !error_reg[2]
    ##1 status_reg[7] ##1 !status_reg[7] && cmd_done) else $error("busy window wrong");
  power_answer_a: assert property (accpq |-> ##2 !error_reg[2] &&
    sector_count == ($past(power_state[1]) ? 8'h00 : 8'hff)) else $error("power code wrong");
  count_kept_a: assert property (acc51 |-> ##2 sector_count == $past(sector_count, 2))
    else $error("count changed");
  abort_flags_a: assert property (acc51 && bad |-> ##2 error_reg[2] && status_reg[0])
    else $error("abort flags missing");
  abort_keeps_a: assert property (acc51 && bad |-> ##3 stream_valid == $past(stream_valid, 3)
    && stream_write_dir == $past(stream_write_dir, 3)) else $error("slot changed on abort");
  add_stores_a: assert property (add_p) else $error("add not stored");
  remove_clears_a: assert property (rem_p) else $error("remove failed");
  done_pulse_a: assert property (cmd_done |=> !cmd_done && !status_reg[7])
    else $error("done not a pulse");
  unhandled_pulse_a: assert property (acc_other |-> ##2 cmd_unhandled && !error_reg[2]
    ##1 !cmd_unhandled) else $error("unknown code not flagged");
  known_quiet_a: assert property ((accpq || acc51) |-> ##2 !cmd_unhandled)
    else $error("known code flagged");
  cover property (acc_other);
  cover property (accpq);
  cover property (acc51 && bad);
  cover property (acc51 && !bad && !feature_cur[7]);
endmodule
bind pwr_stream_cmd pwr_stream_monitor #(.n_streams(n_streams)) mon (.clk(clk), .rst_n(rst_n),
  .cmd_write(cmd_write), .cmd_code(cmd_code), .feature_cur(feature_cur),
  .power_state(power_state), .streaming_supported(streaming_supported),
  .sector_count(sector_count), .error_reg(error_reg), .status_reg(status_reg),
  .cmd_done(cmd_done), .cmd_unhandled(cmd_unhandled), .stream_valid(stream_valid),
  .stream_write_dir(stream_write_dir));
`default_nettype wire

// *** sim/host_adapter_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_adapter_model (
  // completion from the device
  input wire logic  clk,
  input wire logic  cmd_done,
  // command block writes
  output logic       cmd_write,
  output logic [7:0] cmd_code,
  output logic [7:0] feature_cur,
  output logic [7:0] feature_prev
);
  initial begin
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    feature_cur = 8'h00;
    feature_prev = 8'h00;
  end
  // one command per call; code and feature_cur inverted after accept so stale values never look valid
  task issue(input logic [7:0] code, input logic [7:0] feat, input logic [7:0] prev);
    @(posedge clk);
    cmd_write <= 1'b1;
    cmd_code <= code;
    feature_cur <= feat;
    feature_prev <= prev;
    @(posedge clk);
    cmd_write <= 1'b0;
    cmd_code <= ~code;
    feature_cur <= ~feat;
    for (int i = 0; i < 8 && cmd_done !== 1'b1; i++) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** sim/power_query_stream_config_cmds_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module power_query_stream_config_cmds_bench;
  typedef struct packed {
    logic [7:0] code, feat;
    logic [1:0] ps;
    logic sup;
    logic [7:0] cnt, err, vld, dir;
  } row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pwr_stream_pkg::power_state_t ps = pwr_stream_pkg::pwr_active;
  logic sup = 1'b1;
  wire logic cmd_write, cmd_done, unh;
  wire logic [7:0] cmd_code, feat, prev, cnt, err, stat, vld, dir;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  int unh_cnt = 0;
  // code, feature, power state, supported, count, error, valid, dir
  row_t rows [10] = '{
    '{8'he5, 8'h00, 2'h0, 1'h1, 8'hff, 8'h00, 8'h00, 8'h00},
    '{8'h98, 8'h00, 2'h1, 1'h1, 8'hff, 8'h00, 8'h00, 8'h00},
    '{8'he5, 8'h00, 2'h2, 1'h1, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h98, 8'h00, 2'h3, 1'h1, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h51, 8'hc3, 2'h0, 1'h1, 8'h00, 8'h00, 8'h08, 8'h08},
    '{8'h51, 8'h83, 2'h0, 1'h1, 8'h00, 8'h00, 8'h08, 8'h00},
    '{8'h51, 8'h05, 2'h0, 1'h1, 8'h00, 8'h04, 8'h08, 8'h00},
    '{8'h51, 8'h03, 2'h0, 1'h1, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h51, 8'hc7, 2'h0, 1'h0, 8'h00, 8'h04, 8'h00, 8'h00},
    '{8'h51, 8'hc0, 2'h0, 1'h1, 8'h00, 8'h00, 8'h01, 8'h01}};
  always #4 clk = ~clk;
  host_adapter_model host (.clk(clk), .cmd_done(cmd_done), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .feature_cur(feat), .feature_prev(prev));
  pwr_stream_cmd uut (.clk(clk), .rst_n(rst_n), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .feature_cur(feat), .feature_prev(prev), .power_state(ps), .streaming_supported(sup),
    .sector_count(cnt), .error_reg(err), .status_reg(stat), .cmd_done(cmd_done),
    .cmd_unhandled(unh), .stream_valid(vld), .stream_write_dir(dir));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task stop_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard, the whole run needs about 80 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 600) begin
      error_cnt++;
      stop_test();
    end
  end
  // the unknown-code flag stands one cycle only, so count it at every edge
  always @(posedge clk) begin
    if (unh === 1'b1) unh_cnt <= unh_cnt + 1;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(stat, 8'h50);
    check(err | cnt | vld, 8'h00);
    foreach (rows[i]) begin
      ps <= pwr_stream_pkg::power_state_t'(rows[i].ps);
      sup <= rows[i].sup;
      host.issue(rows[i].code, rows[i].feat, 8'h5a);
      check(cnt, rows[i].cnt);
      check(err, rows[i].err);
      check(stat, {7'h28, rows[i].err[2]});
      check(vld, rows[i].vld);
      check(dir & vld, rows[i].dir);
    end
    // known codes never raise the unknown-code flag
    check(8'(unh_cnt), 8'h00);
    // add on a valid id while unsupported aborts and keeps the old slot
    sup <= 1'b0;
    host.issue(8'h51, 8'h80, 8'ha5);
    check(err, 8'h04);
    check(stat, 8'h51);
    check(vld, 8'h01);
    check(dir, 8'h01);
    // a code for another handler is flagged once and sets no error
    sup <= 1'b1;
    host.issue(8'h00, 8'h00, 8'h00);
    check(8'(unh_cnt), 8'h01);
    check(err, 8'h00);
    check(cnt, 8'h00);
    // second reset in mid-run drops every stored stream
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(vld, 8'h00);
    check(stat, 8'h50);
    // the first command after the release is taken normally
    ps <= pwr_stream_pkg::pwr_active;
    host.issue(8'he5, 8'h00, 8'h00);
    check(cnt, 8'hff);
    stop_test();
  end
endmodule
`default_nettype wire
